// *** design/cca_ccm.sv ***
// Shared constants and one compare/capture module of the counter array
`default_nettype none

package cca_pkg;
	localparam int          CCA_CNT_W      = 16;
	localparam int          CCA_NUM_MOD    = 2;
	localparam logic [15:0] CCA_CNT_RST    = 16'h0000;
	localparam logic [15:0] CCA_CNT_MAX    = 16'hffff;
	localparam logic [2:0]  CCA_DIV6_LAST  = 3'h5;
	localparam logic [2:0]  CCA_PRE_RST    = 3'h0;
	localparam int          CCA_PWM_W      = 8;
	localparam logic [1:0]  CCA_SRC_DIV6   = 2'h0;
	localparam logic [1:0]  CCA_SRC_DIV2   = 2'h1;
	localparam logic [1:0]  CCA_SRC_T0OVF  = 2'h2;
	localparam logic [1:0]  CCA_SRC_EXT    = 2'h3;

	typedef enum logic [2:0] {
		CCA_MODE_OFF,
		CCA_MODE_CAP_RISE,
		CCA_MODE_CAP_FALL,
		CCA_MODE_CAP_BOTH,
		CCA_MODE_SW_TIMER,
		CCA_MODE_HS_OUT,
		CCA_MODE_PWM
	} cca_mode_type;

	// Modes in which the module owns its pin as an output
	function automatic logic cca_drives_pin(input cca_mode_type m);
		return (m == CCA_MODE_HS_OUT) || (m == CCA_MODE_PWM);
	endfunction : cca_drives_pin
endpackage : cca_pkg

module cca_ccm (
	// Clock and synchronised reset
	input  wire logic                       clock_i,
	input  wire logic                       rst_n_i,
	// Configuration
	input  wire cca_pkg::cca_mode_type      mode_i,
	input  wire logic [15:0]                cmp_i,
	// Shared time base
	input  wire logic [15:0]                count_i,
	input  wire logic                       tick_i,
	// Pin and flag handling
	input  wire logic                       pin_i,
	input  wire logic                       flag_clr_i,
	output logic      [15:0]                capture_o,
	output logic                            flag_o,
	output logic                            level_o
);
	import cca_pkg::*;

	logic        pin_prev_q, pin_prev_d;
	logic [15:0] cap_q, cap_d;
	logic        flag_q, flag_d;
	logic        lvl_q, lvl_d;
	logic        rise, fall, cap_evt, match, func_evt;

	always_comb begin
		rise     = pin_i & ~pin_prev_q;
		fall     = ~pin_i & pin_prev_q;
		match    = tick_i && (count_i == cmp_i);
		cap_evt  = 1'b0;
		// R03 mode selection
		case (mode_i)
			CCA_MODE_CAP_RISE: cap_evt = rise;
			CCA_MODE_CAP_FALL: cap_evt = fall;
			CCA_MODE_CAP_BOTH: cap_evt = rise | fall;
			default:           cap_evt = 1'b0;
		endcase
		func_evt   = cap_evt
			|| (match && (mode_i == CCA_MODE_SW_TIMER || mode_i == CCA_MODE_HS_OUT));
		pin_prev_d = pin_i;
		cap_d      = cap_evt ? count_i : cap_q;
		// R04 flag on function, set wins
		flag_d     = func_evt | (flag_q & ~flag_clr_i);
		lvl_d      = lvl_q;
		if (mode_i == CCA_MODE_HS_OUT && match) begin
			lvl_d = ~lvl_q;
		end else if (mode_i == CCA_MODE_PWM) begin
			lvl_d = count_i[CCA_PWM_W-1:0] >= cmp_i[CCA_PWM_W-1:0];
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// Idle pin level is the pull-up high, so no false edge after reset
			pin_prev_q <= 1'b1;
			cap_q      <= CCA_CNT_RST;
			flag_q     <= 1'b0;
			lvl_q      <= 1'b0;
		end else begin
			pin_prev_q <= pin_prev_d;
			cap_q      <= cap_d;
			flag_q     <= flag_d;
			lvl_q      <= lvl_d;
		end
	end

	assign capture_o = cap_q;
	assign flag_o    = flag_q;
	assign level_o   = lvl_q;

	property p_capture_value;
		@(posedge clock_i) disable iff (!rst_n_i)
		(mode_i == CCA_MODE_CAP_BOTH && pin_i != pin_prev_q) |=> (cap_q == $past(count_i)) && flag_q;
	endproperty
	a_capture_value: assert property (p_capture_value) else $error("capture missed count"); // R03

	property p_sw_timer_flag;
		@(posedge clock_i) disable iff (!rst_n_i)
		(mode_i == CCA_MODE_SW_TIMER && tick_i && count_i == cmp_i) |=> flag_q;
	endproperty
	a_sw_timer_flag: assert property (p_sw_timer_flag) else $error("timer match flag not set"); // R04

	property p_hso_toggle;
		@(posedge clock_i) disable iff (!rst_n_i)
		(mode_i == CCA_MODE_HS_OUT && match) |=> (lvl_q != $past(lvl_q)) && flag_q;
	endproperty
	a_hso_toggle: assert property (p_hso_toggle) else $error("high-speed output not toggled"); // R04
endmodule : cca_ccm

`default_nettype wire

// *** design/cca_top.sv ***
// Counter array: shared 16-bit time base with two compare/capture modules
`default_nettype none

// Behaviour
// R01: One dedicated 16-bit timer is the common time base for both compare/capture modules.
// R02: Two select bits pick the timer source: clock/6, clock/2, each Timer 0 overflow, or the external count pin.
// R03: Each module runs in capture on rising, falling or both edges, software timer, high-speed output or PWM mode.
// R04: In capture, software timer and high-speed output modes a module raises a flag when it performs its function.
// R05: The timer overflow flag and both module flags merge into one interrupt request.
// R06: The count pin and the two module pins are dedicated, and pins not used by the array act as plain I/O. Software timer mode forces its pin to input.
// R07: The timer wraps from all ones to zero and sets an overflow flag that software clears.
module cca_top (
	// Clock and reset
	input  wire logic                  clock_i,
	input  wire logic                  resetn_i,
	// Time base control
	input  wire logic                  run_i,
	input  wire logic                  count_source_sel_hi_i,
	input  wire logic                  count_source_sel_lo_i,
	input  wire logic                  t0_overflow_i,
	input  wire logic                  ovf_clr_i,
	// Module configuration
	input  wire cca_pkg::cca_mode_type module0_mode_i,
	input  wire cca_pkg::cca_mode_type module1_mode_i,
	input  wire logic [15:0]           module0_cmp_i,
	input  wire logic [15:0]           module1_cmp_i,
	input  wire logic [1:0]            module_int_en_i,
	input  wire logic [1:0]            module_flag_clr_i,
	// Pins: external count, module 0, module 1
	input  wire logic                  ext_count_in_i,
	input  wire logic                  module0_io_i,
	input  wire logic                  module1_io_i,
	input  wire logic                  ext_count_use_i,
	input  wire logic [2:0]            gpio_out_i,
	input  wire logic [2:0]            gpio_oe_i,
	output logic                       ext_count_in_o,
	output logic                       ext_count_in_oe_o,
	output logic                       module0_io_o,
	output logic                       module0_io_oe_o,
	output logic                       module1_io_o,
	output logic                       module1_io_oe_o,
	// Status
	output logic [15:0]                count_o,
	output logic [15:0]                module0_capture_o,
	output logic [15:0]                module1_capture_o,
	output logic                       ovf_flag_o,
	output logic [1:0]                 module_flag_o,
	output logic                       irq_o
);
	import cca_pkg::*;

	logic        rst_meta_q, rst_sync_q;
	logic [2:0]  pre_q, pre_d;
	logic        div2_q, div2_d;
	logic        ext_prev_q, ext_prev_d;
	logic [15:0] cnt_q, cnt_d;
	logic        ovf_q, ovf_d;
	logic        irq_q, irq_d;
	logic [2:0]  pin_out_q, pin_out_d, pin_oe_q, pin_oe_d;
	logic [15:0] cap_q [CCA_NUM_MOD];
	logic [15:0] cap_d [CCA_NUM_MOD];
	logic [1:0]  sel;
	logic        div6_pulse, ext_fall, tick, wrap;
	logic [1:0]  mflag, mlevel;
	logic [15:0] mcap [CCA_NUM_MOD];
	cca_mode_type mmode [CCA_NUM_MOD];
	logic [15:0] mcmp [CCA_NUM_MOD];
	logic [1:0]  mpin;

	// Reset release through two flops
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign mmode[0] = module0_mode_i;
	assign mmode[1] = module1_mode_i;
	assign mcmp[0]  = module0_cmp_i;
	assign mcmp[1]  = module1_cmp_i;
	assign mpin     = {module1_io_i, module0_io_i};

	// Time base
	always_comb begin
		sel        = {count_source_sel_hi_i, count_source_sel_lo_i};
		div6_pulse = run_i && (pre_q == CCA_DIV6_LAST);
		ext_fall   = ext_prev_q & ~ext_count_in_i;
		// R02 source select
		case (sel)
			CCA_SRC_DIV6:  tick = div6_pulse;
			CCA_SRC_DIV2:  tick = run_i && div2_q;
			CCA_SRC_T0OVF: tick = run_i && t0_overflow_i;
			CCA_SRC_EXT:   tick = run_i && ext_fall;
			default:       tick = 1'b0;
		endcase
		pre_d      = pre_q;
		div2_d     = div2_q;
		if (run_i) begin
			pre_d  = (pre_q == CCA_DIV6_LAST) ? CCA_PRE_RST : pre_q + 3'h1;
			div2_d = ~div2_q;
		end
		ext_prev_d = ext_count_in_i;
		wrap       = tick && (cnt_q == CCA_CNT_MAX);
		// R01 shared counter, R07 wrap
		cnt_d      = tick ? cnt_q + 16'h0001 : cnt_q;
		ovf_d      = wrap | (ovf_q & ~ovf_clr_i);
		// R05 merged request
		irq_d      = ovf_q | (|(mflag & module_int_en_i));
	end

	always_ff @(posedge clock_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pre_q      <= CCA_PRE_RST;
			div2_q     <= 1'b0;
			ext_prev_q <= 1'b0;
			cnt_q      <= CCA_CNT_RST;
			ovf_q      <= 1'b0;
			irq_q      <= 1'b0;
		end else begin
			pre_q      <= pre_d;
			div2_q     <= div2_d;
			ext_prev_q <= ext_prev_d;
			cnt_q      <= cnt_d;
			ovf_q      <= ovf_d;
			irq_q      <= irq_d;
		end
	end

	// Compare/capture modules
	generate
		for (genvar g = 0; g < CCA_NUM_MOD; g++) begin : g_mod
			cca_ccm u_ccm (
				.clock_i    (clock_i),
				.rst_n_i    (rst_sync_q),
				.mode_i     (mmode[g]),
				.cmp_i      (mcmp[g]),
				.count_i    (cnt_q),
				.tick_i     (tick),
				.pin_i      (mpin[g]),
				.flag_clr_i (module_flag_clr_i[g]),
				.capture_o  (mcap[g]),
				.flag_o     (mflag[g]),
				.level_o    (mlevel[g])
			);
		end
	endgenerate

	// Pin ownership and output registers
	always_comb begin
		pin_out_d = gpio_out_i;
		pin_oe_d  = gpio_oe_i;
		// R06 claimed pins
		if (ext_count_use_i) begin
			pin_oe_d[0] = 1'b0;
		end
		for (int i = 0; i < CCA_NUM_MOD; i++) begin
			cap_d[i] = mcap[i];
			if (cca_drives_pin(mmode[i])) begin
				pin_out_d[i+1] = mlevel[i];
				pin_oe_d[i+1]  = 1'b1;
			end else if (mmode[i] != CCA_MODE_OFF) begin
				pin_oe_d[i+1]  = 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pin_out_q <= 3'h0;
			pin_oe_q  <= 3'h0;
			for (int i = 0; i < CCA_NUM_MOD; i++) begin
				cap_q[i] <= CCA_CNT_RST;
			end
		end else begin
			pin_out_q <= pin_out_d;
			pin_oe_q  <= pin_oe_d;
			for (int i = 0; i < CCA_NUM_MOD; i++) begin
				cap_q[i] <= cap_d[i];
			end
		end
	end

	assign ext_count_in_o    = pin_out_q[0];
	assign ext_count_in_oe_o = pin_oe_q[0];
	assign module0_io_o      = pin_out_q[1];
	assign module0_io_oe_o   = pin_oe_q[1];
	assign module1_io_o      = pin_out_q[2];
	assign module1_io_oe_o   = pin_oe_q[2];
	assign count_o           = cnt_q;
	assign module0_capture_o = cap_q[0];
	assign module1_capture_o = cap_q[1];
	assign ovf_flag_o        = ovf_q;
	assign module_flag_o     = mflag;
	assign irq_o             = irq_q;

	property p_count_step;
		@(posedge clock_i) disable iff (!rst_sync_q)
		tick |=> cnt_q == $past(cnt_q) + 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter did not step by one"); // R01

	property p_div6_spacing;
		@(posedge clock_i) disable iff (!rst_sync_q)
		div6_pulse |=> !div6_pulse [*5];
	endproperty
	a_div6_spacing: assert property (p_div6_spacing) else $error("divide-by-six ticks too close"); // R02

	property p_div2_tick;
		@(posedge clock_i) disable iff (!rst_sync_q)
		(sel == CCA_SRC_DIV2 && run_i && tick) ##1 (sel == CCA_SRC_DIV2) |-> !tick && !div2_q;
	endproperty
	a_div2_tick: assert property (p_div2_tick) else $error("divide-by-two phase wrong"); // R02

	property p_irq_merge;
		@(posedge clock_i) disable iff (!rst_sync_q)
		(ovf_q || |(mflag & module_int_en_i)) |=> irq_q;
	endproperty
	a_irq_merge: assert property (p_irq_merge) else $error("merged request missing"); // R05

	property p_pin_release;
		@(posedge clock_i) disable iff (!rst_sync_q)
		(module0_mode_i == CCA_MODE_OFF) |=> module0_io_oe_o == $past(gpio_oe_i[1]);
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("unused pin not plain I/O"); // R06

	property p_wrap;
		@(posedge clock_i) disable iff (!rst_sync_q)
		wrap |=> (cnt_q == CCA_CNT_RST) && ovf_q;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap or overflow flag wrong"); // R07

	c_wrap:    cover property (@(posedge clock_i) disable iff (!rst_sync_q) wrap);
	c_irq:     cover property (@(posedge clock_i) disable iff (!rst_sync_q) $rose(irq_q));
	c_ext_cnt: cover property (@(posedge clock_i) disable iff (!rst_sync_q) sel == CCA_SRC_EXT && tick);
endmodule : cca_top

`default_nettype wire

// *** test/cca_pins.sv ***
// Pin-side model: pulled-up lines driven by the board or the design
`default_nettype none
module cca_pins (
	// Board drive
	input  wire logic [2:0] drv_en_i,
	input  wire logic [2:0] drv_val_i,
	// Design drive
	input  wire logic [2:0] dut_out_i,
	input  wire logic [2:0] dut_oe_i,
	// Resolved levels
	output logic      [2:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			level_o[i] = dut_oe_i[i] ? dut_out_i[i] : (drv_en_i[i] ? drv_val_i[i] : 1'b1);
		end
	end
endmodule : cca_pins
`default_nettype wire

// *** test/cca_top_tb.sv ***
// Self-checking bench for the counter array
`default_nettype none
module cca_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cca_pkg::*;
	typedef struct {int sel; logic [15:0] exp;} cca_note_type;
	logic         clk, rst_n, run, sel_hi, sel_lo, t0, oclr, use_ext, ovf, irq;
	cca_mode_type m0, m1;
	logic [15:0]  c0, c1, cnt, cap0, cap1, exp_cnt, rnd;
	logic [1:0]   ien, fclr, mflag;
	logic [2:0]   gout, goe, lvl, den, dval;
	wire logic [2:0] dout, doe;
	int           n_errors, check_count, cyc;
	cca_note_type notes[$];
	cca_note_type e;
	string        nm[8] = '{"count", "cap0", "cap1", "ovf", "mflag", "irq", "pin", "oe"};

	cca_top u_cca_top (.clock_i(clk), .resetn_i(rst_n), .run_i(run), .count_source_sel_hi_i(sel_hi),
		.count_source_sel_lo_i(sel_lo), .t0_overflow_i(t0), .ovf_clr_i(oclr), .module0_mode_i(m0),
		.module1_mode_i(m1), .module0_cmp_i(c0), .module1_cmp_i(c1), .module_int_en_i(ien),
		.module_flag_clr_i(fclr), .ext_count_in_i(lvl[0]), .module0_io_i(lvl[1]), .module1_io_i(lvl[2]),
		.ext_count_use_i(use_ext), .gpio_out_i(gout), .gpio_oe_i(goe), .ext_count_in_o(dout[0]),
		.ext_count_in_oe_o(doe[0]), .module0_io_o(dout[1]), .module0_io_oe_o(doe[1]),
		.module1_io_o(dout[2]), .module1_io_oe_o(doe[2]), .count_o(cnt), .module0_capture_o(cap0),
		.module1_capture_o(cap1), .ovf_flag_o(ovf), .module_flag_o(mflag), .irq_o(irq));
	cca_pins u_cca_pins (.drv_en_i(den), .drv_val_i(dval), .dut_out_i(dout), .dut_oe_i(doe), .level_o(lvl));

	function automatic logic [15:0] obs(input int s);
		case (s)
			0: return cnt;
			1: return cap0;
			2: return cap1;
			3: return {15'h0000, ovf};
			4: return {14'h0000, mflag};
			5: return {15'h0000, irq};
			6: return {13'h0000, dout};
			default: return {13'h0000, doe};
		endcase
	endfunction : obs

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic note(input int s, input logic [15:0] v);
		notes.push_back('{s, v});
	endtask : note

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict

	// Run the timer for n ticks of source s
	task automatic ticks(input logic [1:0] s, input int n);
		{sel_hi, sel_lo} = s;
		run = 1'b1;
		if (s == CCA_SRC_DIV6) begin
			step(6 * n);
		end else if (s == CCA_SRC_DIV2) begin
			step(2 * n);
		end else if (s == CCA_SRC_T0OVF) begin
			t0 = 1'b1;
			step(n);
			t0 = 1'b0;
		end else begin
			repeat (n) begin
				dval[0] = 1'b1;
				step(2);
				dval[0] = 1'b0;
				step(2);
			end
			step(2);
		end
		run = 1'b0;
		exp_cnt = exp_cnt + 16'(n);
	endtask : ticks

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			$display("ERROR run_time expected %0d seen %0d", 90000, cyc);
			give_verdict();
		end
	end

	// Compare noted expectations while outputs are settled
	always @(negedge clk) begin
		#1;
		while (notes.size() > 0) begin
			e = notes.pop_front();
			chk(nm[e.sel], obs(e.sel), e.exp);
		end
	end

	initial begin
		{rst_n, run, sel_hi, sel_lo, t0, oclr, use_ext} = '0;
		m0 = CCA_MODE_OFF;
		m1 = CCA_MODE_OFF;
		{c0, c1, ien, fclr, gout, goe, dval} = '0;
		den = 3'h7;
		exp_cnt = 16'h0000;
		rnd = 16'hacc2;
		step(2);
		rst_n = 1'b1;
		step(3);
		note(0, 16'h0000);
		note(5, 16'h0000);
		use_ext = 1'b1;
		for (int s = 0; s < 4; s++) begin
			rnd = lfsr(rnd);
			ticks(2'(s), 5 + int'(rnd[3:0]));
			note(0, exp_cnt);
		end
		{sel_hi, sel_lo} = CCA_SRC_T0OVF;
		t0 = 1'b1;
		step(3);
		t0 = 1'b0;
		note(0, exp_cnt);
		$display("test sources done");
		m0 = CCA_MODE_CAP_RISE;
		m1 = CCA_MODE_CAP_FALL;
		ien = 2'h3;
		step(2);
		dval[2:1] = 2'h3;
		step(3);
		note(1, exp_cnt);
		note(2, 16'h0000);
		note(4, 16'h0001);
		note(5, 16'h0001);
		note(7, 16'h0000);
		fclr = 2'h3;
		step(1);
		fclr = 2'h0;
		ien = 2'h0;
		m0 = CCA_MODE_CAP_BOTH;
		dval[2:1] = 2'h0;
		step(3);
		note(2, exp_cnt);
		note(4, 16'h0003);
		note(5, 16'h0000);
		fclr = 2'h3;
		step(1);
		fclr = 2'h0;
		$display("test capture done");
		m0 = CCA_MODE_HS_OUT;
		m1 = CCA_MODE_SW_TIMER;
		c0 = exp_cnt + 16'h0003;
		c1 = exp_cnt + 16'h0005;
		ticks(CCA_SRC_T0OVF, 6);
		step(1);
		note(4, 16'h0003);
		note(6, 16'h0002);
		note(7, 16'h0002);
		m1 = CCA_MODE_PWM;
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			c1 = (i == 2) ? rnd : exp_cnt + 16'(i);
			step(3);
			note(6, {13'h0000, exp_cnt[7:0] >= c1[7:0], 2'h2});
			note(7, 16'h0006);
		end
		$display("test outputs done");
		m0 = CCA_MODE_OFF;
		m1 = CCA_MODE_OFF;
		use_ext = 1'b0;
		den = 3'h0;
		gout = 3'h5;
		goe = 3'h7;
		step(3);
		note(6, 16'h0005);
		note(7, 16'h0007);
		use_ext = 1'b1;
		step(3);
		note(7, 16'h0006);
		goe = 3'h0;
		den = 3'h7;
		ticks(CCA_SRC_T0OVF, int'(16'hffff - exp_cnt));
		note(0, 16'hffff);
		note(3, 16'h0000);
		ticks(CCA_SRC_T0OVF, 1);
		note(0, 16'h0000);
		note(3, 16'h0001);
		step(1);
		note(5, 16'h0001);
		oclr = 1'b1;
		step(1);
		oclr = 1'b0;
		note(3, 16'h0000);
		step(1);
		note(5, 16'h0000);
		$display("test wrap done");
		step(2);
		give_verdict();
	end
endmodule : cca_top_tb
`default_nettype wire
